/* design/prt_pkg.sv */
// Shared constants, types and helpers of the paged register two-wire target
package prt_pkg;

   // Target address: upper five bits fixed, low two from the strap pin
   localparam logic [4:0] DEV_ADDR_HI     = 5'h1D;
   localparam logic [1:0] STRAP_GND       = 2'h0;
   localparam logic [1:0] STRAP_VCC       = 2'h3;
   localparam logic [1:0] STRAP_SCL       = 2'h1;
   localparam logic [1:0] STRAP_SDA       = 2'h2;

   // Register pointer values with side effects
   localparam logic [7:0] PAGE_SEL_PTR    = 8'hFD;
   localparam logic [7:0] SHDN_PTR        = 8'h0A;

   // Page select decode
   localparam logic [7:0] LAST_FRAME_PAGE = 8'h07;
   localparam logic [7:0] FUNC_PAGE       = 8'h0B;

   // Reset values
   localparam logic [7:0] PAGE_RST        = 8'h00;
   localparam logic [7:0] PTR_RST         = 8'h00;
   localparam logic [7:0] SHDN_RST        = 8'h00;
   localparam int         SHDN_RUN_BIT    = 0;

   // Bit counter value after the eighth clock rise of a byte
   localparam logic [3:0] BIT_LAST        = 4'h8;

   // Register storage: eight frame pages plus the function page
   localparam int         MEM_AW          = 12;
   localparam int         MEM_DEPTH       = 2304;
   localparam logic [3:0] MEM_FUNC_IDX    = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE       = 4'b0000,
      ST_ADDR       = 4'b0001,
      ST_ADDR_ACK   = 4'b0010,
      ST_PTR        = 4'b0011,
      ST_PTR_ACK    = 4'b0100,
      ST_WDATA      = 4'b0101,
      ST_WDATA_ACK  = 4'b0110,
      ST_RDATA      = 4'b0111,
      ST_RDATA_ACK  = 4'b1000
   } prt_state_type;

   typedef struct packed {
      logic scl;
      logic sda;
      logic strap;
      logic shdn_n;
   } prt_pins_type;

   typedef struct packed {
      logic              we;
      logic [MEM_AW-1:0] addr;
      logic [7:0]        data;
   } prt_mem_wr_type;

   function automatic logic page_is_frame(input logic [7:0] page);
      page_is_frame = (page <= LAST_FRAME_PAGE);
   endfunction

   function automatic logic page_is_valid(input logic [7:0] page);
      page_is_valid = page_is_frame(page) || (page == FUNC_PAGE);
   endfunction

   function automatic logic [MEM_AW-1:0] mem_index(input logic [7:0] page, input logic [7:0] ptr);
      mem_index = (page == FUNC_PAGE) ? {MEM_FUNC_IDX, ptr} : {page[3:0], ptr};
   endfunction

endpackage

/* design/prt_reg_mem.sv */
// Byte storage for the frame and function pages, registered read data
`timescale 1ns/1ns
module prt_reg_mem
   import prt_pkg::*;
(
   input  wire logic              i_core_clk, // Core clock
   input  wire logic              i_rst,      // Synchronous reset, clears read data only
   input  wire prt_mem_wr_type    i_wr,       // Write strobe, address and data
   input  wire logic              i_re,       // Read strobe
   input  wire logic [MEM_AW-1:0] i_raddr,    // Read address
   output logic      [7:0]        o_rdata     // Read data, one cycle after i_re
);

   // Contents are not reset, like the frame storage they model
   logic [7:0] mem_r [MEM_DEPTH];

   always_ff @(posedge i_core_clk) begin
      if (i_wr.we) begin
         mem_r[i_wr.addr] <= i_wr.data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_re) begin
         o_rdata <= mem_r[i_raddr];
      end
   end

endmodule

/* design/prt_target.sv */
// Two-wire serial target port with paged register space
//
// Summary of operation
// - Answer target address 11101 followed by the two strap-derived bits.
// - Eighth address bit picks direction: zero writes, one reads.
// - Strap bits: ground 00, supply 11, clock line 01, data line 10.
// - Data sampled while clock high; data line rests high when idle.
// - Data falling while clock high is START; address compare follows.
// - Pull data low in the ninth clock pulse to acknowledge own address.
// - Accept and acknowledge the register pointer byte, MSB first.
// - Data bytes arrive MSB first; acknowledge each one.
// - Data rising while clock high is STOP and ends the transfer.
// - Pointer advances by one during each data byte acknowledge.
// - Auto increment continues for any number of written bytes.
// - Frame page reads give data only with shutdown pin high and software shutdown.
// - Function page reads work in normal operation and software shutdown.
// - In read phase drive the selected register contents onto data line.
// - Page values 00-07 select frames, 0B the function page, others reserved.
// - Software shutdown is controlled by function page register 0Ah.
`timescale 1ns/1ns
module prt_target
   import prt_pkg::*;
(
   input  wire logic       i_core_clk,       // Core clock, 100 MHz
   input  wire logic       i_rst,            // Synchronous reset, active high
   input  wire logic       i_scl,            // Serial clock from the master, link clock
   input  wire logic       i_sda,            // Serial data line level
   output logic            o_sda,            // Serial data drive value, always low
   output logic            o_sda_oe_n,       // Serial data enable, low pulls the line low
   input  wire logic       i_strap_pin,      // Address select strap pin level
   input  wire logic       i_shutdown_pin_n, // Shutdown pin, low shuts the chip down
   output logic            o_sw_shutdown,    // Software shutdown active
   output logic [7:0]      o_page_select     // Current page select value
);

   // Link domain: shift in data on each real clock rise
   logic [7:0] rx_sr_r;

   always_ff @(posedge i_scl) begin
      rx_sr_r <= {rx_sr_r[6:0], i_sda};
   end

   // Pin synchronisers, stage one feeds only stage two; unreset so a grounded strap never looks high
   prt_pins_type pins_s1_r;
   prt_pins_type pins_s2_r;
   prt_pins_type pins_s3_r;

   always_ff @(posedge i_core_clk) begin
      pins_s1_r <= '{scl: i_scl, sda: i_sda, strap: i_strap_pin, shdn_n: i_shutdown_pin_n};
      pins_s2_r <= pins_s1_r;
      pins_s3_r <= pins_s2_r;
   end

   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;

   assign scl_rise  = pins_s2_r.scl & ~pins_s3_r.scl;
   assign scl_fall  = ~pins_s2_r.scl & pins_s3_r.scl;
   assign start_evt = pins_s2_r.scl & pins_s3_r.scl & pins_s3_r.sda & ~pins_s2_r.sda;
   assign stop_evt  = pins_s2_r.scl & pins_s3_r.scl & ~pins_s3_r.sda & pins_s2_r.sda;

   // Strap decode: watch whether the pin is static or follows a bus line
   logic       strap_seen_hi_r;
   logic       strap_seen_lo_r;
   logic       strap_off_scl_r;
   logic       strap_off_sda_r;
   logic       lines_stable;
   logic [1:0] strap_bits;

   assign lines_stable = (pins_s2_r.scl == pins_s3_r.scl) && (pins_s2_r.sda == pins_s3_r.sda)
                         && (pins_s2_r.strap == pins_s3_r.strap);

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         strap_seen_hi_r <= 1'b0;
         strap_seen_lo_r <= 1'b0;
         strap_off_scl_r <= 1'b0;
         strap_off_sda_r <= 1'b0;
      end else if (lines_stable) begin
         strap_seen_hi_r <= strap_seen_hi_r | pins_s2_r.strap;
         strap_seen_lo_r <= strap_seen_lo_r | ~pins_s2_r.strap;
         strap_off_scl_r <= strap_off_scl_r | (pins_s2_r.strap != pins_s2_r.scl);
         strap_off_sda_r <= strap_off_sda_r | (pins_s2_r.strap != pins_s2_r.sda);
      end
   end

   always_comb begin
      if (!strap_seen_lo_r) begin
         strap_bits = STRAP_VCC;
      end else if (!strap_seen_hi_r) begin
         strap_bits = STRAP_GND;
      end else if (!strap_off_scl_r) begin
         strap_bits = STRAP_SCL;
      end else begin
         strap_bits = STRAP_SDA;
      end
   end

   // Protocol state
   prt_state_type state_r;
   prt_state_type state_nxt;
   logic [3:0]    bit_cnt_r;
   logic          rd_mode_r;
   logic          master_ack_r;
   logic          drive_low_r;
   logic [7:0]    tx_r;
   logic [7:0]    ptr_r;
   logic [7:0]    page_r;
   logic [7:0]    shdn_r;

   // The shift register only moves on a clock rise, and the core samples it
   // after a synchronised fall, so it is static for the whole low phase.
   logic [7:0] rx_byte;
   logic       byte_done;
   logic       in_ack;
   logic       addr_match;
   logic       addr_done;
   logic       addr_hit;
   logic       ptr_done;
   logic       wdata_done;
   logic       wack_end;
   logic       rd_byte_end;
   logic       rack_end;
   logic       tx_shift;

   assign rx_byte     = rx_sr_r;
   assign byte_done   = scl_fall && (bit_cnt_r == BIT_LAST);
   assign in_ack      = (state_r == ST_ADDR_ACK) || (state_r == ST_PTR_ACK) || (state_r == ST_WDATA_ACK)
                        || (state_r == ST_RDATA_ACK);
   assign addr_match  = (rx_byte[7:1] == {DEV_ADDR_HI, strap_bits});
   assign addr_done   = (state_r == ST_ADDR) && byte_done;
   assign addr_hit    = addr_done && addr_match;
   assign ptr_done    = (state_r == ST_PTR) && byte_done;
   assign wdata_done  = (state_r == ST_WDATA) && byte_done;
   assign wack_end    = (state_r == ST_WDATA_ACK) && scl_fall;
   assign rd_byte_end = (state_r == ST_RDATA) && byte_done;
   assign rack_end    = (state_r == ST_RDATA_ACK) && scl_fall;
   assign tx_shift    = ((state_r == ST_ADDR_ACK) && scl_fall && rd_mode_r)
                        || ((state_r == ST_RDATA) && scl_fall && !byte_done)
                        || (rack_end && master_ack_r);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_ADDR: begin
            if (addr_done) begin
               state_nxt = addr_match ? ST_ADDR_ACK : ST_IDLE;
            end
         end
         ST_ADDR_ACK: begin
            if (scl_fall) begin
               state_nxt = rd_mode_r ? ST_RDATA : ST_PTR;
            end
         end
         ST_PTR: begin
            if (ptr_done) begin
               state_nxt = ST_PTR_ACK;
            end
         end
         ST_PTR_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
               state_nxt = ST_WDATA;
            end
         end
         ST_WDATA: begin
            if (wdata_done) begin
               state_nxt = ST_WDATA_ACK;
            end
         end
         ST_RDATA: begin
            if (rd_byte_end) begin
               state_nxt = ST_RDATA_ACK;
            end
         end
         ST_RDATA_ACK: begin
            if (rack_end) begin
               state_nxt = master_ack_r ? ST_RDATA : ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
      end else if (start_evt) begin
         state_r <= ST_ADDR;
      end else if (stop_evt) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || start_evt) begin
         bit_cnt_r <= 4'h0;
      end else if (scl_fall && (byte_done || in_ack)) begin
         bit_cnt_r <= 4'h0;
      end else if (scl_rise && (state_r != ST_IDLE)) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_mode_r    <= 1'b0;
         master_ack_r <= 1'b0;
      end else begin
         if (addr_hit) begin
            rd_mode_r <= rx_byte[0];
         end
         if (scl_rise && (state_r == ST_RDATA_ACK)) begin
            master_ack_r <= ~pins_s2_r.sda;
         end
      end
   end

   // Pointer, page select and software shutdown
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ptr_r  <= PTR_RST;
         page_r <= PAGE_RST;
         shdn_r <= SHDN_RST;
      end else begin
         if (ptr_done) begin
            ptr_r <= rx_byte;
         end else if (wack_end || rd_byte_end) begin
            ptr_r <= ptr_r + 8'h01;
         end
         if (wdata_done && (ptr_r == PAGE_SEL_PTR)) begin
            page_r <= rx_byte;
         end
         if (wdata_done && (page_r == FUNC_PAGE) && (ptr_r == SHDN_PTR)) begin
            shdn_r <= rx_byte;
         end
      end
   end

   // Register storage access; reserved pages neither store nor return data
   prt_mem_wr_type mem_wr;
   logic           rd_req_r;
   logic           rd_valid_r;
   logic [7:0]     mem_rdata;
   logic           sw_shutdown;
   logic           frame_readable;
   logic [7:0]     rd_value;

   assign mem_wr.we      = wdata_done && (ptr_r != PAGE_SEL_PTR) && page_is_valid(page_r);
   assign mem_wr.addr    = mem_index(page_r, ptr_r);
   assign mem_wr.data    = rx_byte;
   assign sw_shutdown    = ~shdn_r[SHDN_RUN_BIT];
   assign frame_readable = pins_s2_r.shdn_n && sw_shutdown;

   prt_reg_mem u_mem (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_wr       (mem_wr),
      .i_re       (rd_req_r),
      .i_raddr    (mem_index(page_r, ptr_r)),
      .o_rdata    (mem_rdata)
   );

   always_comb begin
      if (ptr_r == PAGE_SEL_PTR) begin
         rd_value = page_r;
      end else if (page_r == FUNC_PAGE) begin
         rd_value = mem_rdata;
      end else if (page_is_frame(page_r) && frame_readable) begin
         rd_value = mem_rdata;
      end else begin
         rd_value = 8'h00;
      end
   end

   // Fetch waits one cycle so the pointer increment has landed
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_req_r   <= 1'b0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_req_r   <= (addr_hit && rx_byte[0]) || rd_byte_end;
         rd_valid_r <= rd_req_r;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tx_r <= 8'h00;
      end else if (rd_valid_r) begin
         tx_r <= rd_value;
      end else if (tx_shift) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   // Data line drive, changed only while the clock is low
   always_ff @(posedge i_core_clk) begin
      if (i_rst || start_evt || stop_evt) begin
         drive_low_r <= 1'b0;
      end else if (addr_hit || ptr_done || wdata_done) begin
         drive_low_r <= 1'b1;
      end else if (tx_shift) begin
         drive_low_r <= ~tx_r[7];
      end else if (scl_fall && (in_ack || rd_byte_end)) begin
         drive_low_r <= 1'b0;
      end
   end

   assign o_sda         = 1'b0;
   assign o_sda_oe_n    = ~drive_low_r;
   assign o_sw_shutdown = sw_shutdown;
   assign o_page_select = page_r;

   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_addr_byte_end;
      (state_r == ST_ADDR) && byte_done;
   endsequence
   sequence s_own_addr;
      s_addr_byte_end ##0 addr_match;
   endsequence
   sequence s_read_fetch;
      rd_req_r ##1 rd_valid_r;
   endsequence
   AST_ADDR_FOREIGN: assert property (s_addr_byte_end ##0 !addr_match |=>
      ((state_r == ST_IDLE) && o_sda_oe_n) [*2])
      else $error("foreign address not ignored");
   AST_ADDR_ACK: assert property (s_own_addr |=>
      (state_r == ST_ADDR_ACK) && !o_sda_oe_n)
      else $error("own address not acknowledged");
   AST_DIR_READ: assert property (s_own_addr ##0 rx_byte[0] |=> rd_mode_r ##0 s_read_fetch)
      else $error("read direction not taken");
   AST_STOP_IDLE: assert property (stop_evt |=> (state_r == ST_IDLE) && o_sda_oe_n)
      else $error("stop did not end transfer");
   AST_RESTART_KEEP: assert property (start_evt |=> (state_r == ST_ADDR)
      && (page_r == $past(page_r)) && (ptr_r == $past(ptr_r)))
      else $error("restart lost page or pointer");
   AST_PTR_INC: assert property (wack_end |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer did not advance");
   AST_PAGE_WRITE: assert property (wdata_done && (ptr_r == PAGE_SEL_PTR) |=>
      (o_page_select == $past(rx_byte)) && !$past(mem_wr.we))
      else $error("page select write wrong");
   AST_FRAME_GATE: assert property (s_read_fetch ##0 page_is_frame(page_r) && (ptr_r != PAGE_SEL_PTR)
      && !frame_readable |=> tx_r == 8'h00)
      else $error("frame read not blocked");
   AST_SHDN_REG: assert property (wdata_done && (page_r == FUNC_PAGE) && (ptr_r == SHDN_PTR) |=>
      o_sw_shutdown == !$past(rx_byte[SHDN_RUN_BIT]))
      else $error("shutdown register not applied");
   AST_DATA_ACK_HOLD: assert property ((state_r == ST_WDATA_ACK) && !scl_fall && !start_evt
      && !stop_evt |=> !o_sda_oe_n)
      else $error("data acknowledge released early");

endmodule

/* verification/prt_bus_master.sv */
// Bus master model that drives the two-wire target's serial pins
`timescale 1ns/1ns
module prt_bus_master (
   input  wire logic i_core_clk, // Core clock, paces the bus phases
   input  wire logic i_slow,     // High paces the serial clock below 400 kHz
   input  wire logic i_sda,      // Resolved data line level
   output logic      o_scl,      // Serial clock, stands high when idle
   output logic      o_sda_low   // High pulls the data line low
);
   // Phases are kept long because the target synchronises the pins to the core clock
   localparam int HALF = 12;
   // 1.3 us phases keep the rated clock; too slow for every scenario within the run budget
   localparam int HALF_SLOW = 130;

   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic hold();
      repeat (i_slow ? HALF_SLOW : HALF) @(negedge i_core_clk);
   endtask

   task automatic start();
      o_sda_low = 1'b0;
      hold();
      o_scl = 1'b1;
      hold();
      o_sda_low = 1'b1;
      hold();
      o_scl = 1'b0;
   endtask

   task automatic stop();
      o_sda_low = 1'b1;
      hold();
      o_scl = 1'b1;
      hold();
      o_sda_low = 1'b0;
      hold();
   endtask

   // Data only changes while the clock is low
   task automatic xfer(input logic b, output logic r);
      o_sda_low = ~b;
      hold();
      o_scl = 1'b1;
      hold();
      r     = i_sda;
      o_scl = 1'b0;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], r);
      end
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, r);
         d[i] = r;
      end
      xfer(last, r);
   endtask
endmodule

/* verification/test_paged_register_i2c_target.sv */
// Self-checking bench of the paged register two-wire target
`timescale 1ns/1ns
module test_paged_register_i2c_target
   import prt_pkg::*;
;
   localparam logic [1:0] STRAP_TAB [4] = '{STRAP_GND, STRAP_VCC, STRAP_SCL, STRAP_SDA};
   logic       i_core_clk;
   logic       i_rst;
   logic       i_shutdown_pin_n;
   logic [1:0] strap_sel;
   logic [1:0] bits;
   logic       scl;
   logic       sda_low;
   logic       slow;
   logic       sda;
   logic       strap;
   logic       o_sda;
   logic       o_sda_oe_n;
   logic       o_sw_shutdown;
   logic [7:0] o_page_select;
   int         failures = 0;
   int         checks = 0;

   // Pull-up on the data line; strap order is ground, supply, clock, data
   assign sda   = sda_low ? 1'b0 : (o_sda_oe_n ? 1'b1 : o_sda);
   assign strap = strap_sel[1] ? (strap_sel[0] ? sda : scl) : strap_sel[0];

   prt_target dut (
      .i_core_clk       (i_core_clk),
      .i_rst            (i_rst),
      .i_scl            (scl),
      .i_sda            (sda),
      .o_sda            (o_sda),
      .o_sda_oe_n       (o_sda_oe_n),
      .i_strap_pin      (strap),
      .i_shutdown_pin_n (i_shutdown_pin_n),
      .o_sw_shutdown    (o_sw_shutdown),
      .o_page_select    (o_page_select)
   );

   prt_bus_master master (
      .i_core_clk (i_core_clk),
      .i_slow     (slow),
      .i_sda      (sda),
      .o_scl      (scl),
      .o_sda_low  (sda_low)
   );

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic logic [7:0] adr(input logic rd);
      adr = {DEV_ADDR_HI, bits, rd};
   endfunction

   task automatic wr(input logic [7:0] b);
      logic a;
      master.wbyte(b, a);
      chk({7'h00, a}, 8'h01);
   endtask

   task automatic do_reset();
      i_rst = 1'b1;
      repeat (4) @(negedge i_core_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_core_clk);
   endtask

   // Page select write, then a restart with the register pointer
   task automatic set_ptr(input logic [7:0] page, ptr);
      master.start();
      wr(adr(1'b0));
      wr(PAGE_SEL_PTR);
      wr(page);
      master.start();
      wr(adr(1'b0));
      wr(ptr);
   endtask

   task automatic wr_regs(input logic [7:0] page, ptr, input logic [31:0] d, input int n);
      set_ptr(page, ptr);
      for (int i = 0; i < n; i++) begin
         wr(d[8*i +: 8]);
      end
      master.stop();
      chk({7'h00, o_sda_oe_n}, 8'h01);
   endtask

   task automatic rd_regs(input logic [7:0] page, ptr, input logic [31:0] e, input int n);
      logic [7:0] d;
      set_ptr(page, ptr);
      master.start();
      wr(adr(1'b1));
      for (int i = 0; i < n; i++) begin
         master.rbyte(i == n - 1, d);
         chk(d, e[8*i +: 8]);
      end
      master.stop();
   endtask

   initial begin
      logic a;
      i_rst            = 1'b1;
      i_shutdown_pin_n = 1'b1;
      slow             = 1'b0;
      strap_sel        = 2'h0;
      bits             = STRAP_GND;
      for (int s = 0; s < 4; s++) begin
         strap_sel = s[1:0];
         do_reset();
         chk(o_page_select, PAGE_RST);
         chk({7'h00, o_sw_shutdown}, 8'h01);
         bits = STRAP_TAB[s] ^ 2'h1;
         master.start();
         master.wbyte(adr(1'b0), a);
         chk({7'h00, a}, 8'h00);
         master.stop();
         bits = STRAP_TAB[s];
         master.start();
         wr(adr(1'b0));
         master.stop();
      end
      wr_regs(FUNC_PAGE, SHDN_PTR, 32'h01, 1);
      chk({7'h00, o_sw_shutdown}, 8'h00);
      chk(o_page_select, FUNC_PAGE);
      wr_regs(FUNC_PAGE, 8'h00, 32'h00332211, 3);
      rd_regs(FUNC_PAGE, 8'h00, 32'h00332211, 3);
      wr_regs(LAST_FRAME_PAGE, 8'h10, 32'h5AA5, 2);
      chk(o_page_select, LAST_FRAME_PAGE);
      rd_regs(LAST_FRAME_PAGE, 8'h10, 32'h0000, 2);
      wr_regs(FUNC_PAGE, SHDN_PTR, 32'h00, 1);
      chk({7'h00, o_sw_shutdown}, 8'h01);
      rd_regs(LAST_FRAME_PAGE, 8'h10, 32'h5AA5, 2);
      rd_regs(FUNC_PAGE, 8'h00, 32'h00332211, 3);
      i_shutdown_pin_n = 1'b0;
      rd_regs(LAST_FRAME_PAGE, 8'h10, 32'h0000, 2);
      i_shutdown_pin_n = 1'b1;
      // First value above the frame pages is reserved
      wr_regs(8'h08, 8'h00, 32'h77, 1);
      rd_regs(8'h08, 8'h00, 32'h00, 1);
      // Reserved page shares storage rows with the function page, so it must not have clobbered it
      rd_regs(FUNC_PAGE, 8'h00, 32'h11, 1);
      slow = 1'b1;
      rd_regs(FUNC_PAGE, PAGE_SEL_PTR, {24'h000000, FUNC_PAGE}, 1);
      slow = 1'b0;
      wrap_up();
   end

   // Normal run is a few hundred microseconds
   initial begin
      #1_000_000;
      failures++;
      wrap_up();
   end
endmodule
